// file: design/ckss_sequencer.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "ckss_consts.svh"

module ckss_sequencer #(
	parameter int unsigned TOUT_LONG_CYC = `CKSS_TOUT_LONG_CYC,
	parameter int unsigned OSC_16K_CYC   = `CKSS_OSC_16K_CYC,
	parameter int unsigned OSC_32K_CYC   = `CKSS_OSC_32K_CYC
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic                        device_reset_in,
	input  wire logic [3:0]                  clock_source_select,
	input  wire logic [1:0]                  startup_time_select,
	input  wire logic                        divide_by_eight_fuse,
	input  wire logic                        wdt_osc_pin,
	input  wire logic                        sel_osc_pin,
	input  wire logic                        sleep_enter,
	input  wire logic                        wake_event,
	input  wire logic [1:0]                  reg_addr,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic                        reg_write,
	input  wire logic                        reg_read,
	output logic      [7:0]                  reg_rdata,
	output logic                             internal_reset,
	output logic                             cpu_clock_enable,
	output logic                             flash_interface_clock_enable,
	output logic                             async_timer_clock_enable,
	output logic                             converter_clock_enable,
	output logic                             divide_by_eight,
	output ckss_pkg::ckss_source_e           clock_source,
	output logic      [2:0]                  oscillator_range_select,
	output logic                             config_reserved
);

	localparam logic [`CKSS_CNT_W-1:0] LONG_CYC = `CKSS_CNT_W'(TOUT_LONG_CYC);
	localparam logic [`CKSS_CNT_W-1:0] C16K_CYC = `CKSS_CNT_W'(OSC_16K_CYC);
	localparam logic [`CKSS_CNT_W-1:0] C32K_CYC = `CKSS_CNT_W'(OSC_32K_CYC);

	logic [3:0]                   fuse_cksel;
	logic [1:0]                   fuse_sut;
	logic                         fuse_div8;
	logic [2:0]                   control;
	ckss_pkg::ckss_state_e        state;
	ckss_pkg::ckss_state_e        next_state;
	ckss_pkg::ckss_source_e       next_source;
	ckss_pkg::ckss_tout_e         tout_sel;
	logic [`CKSS_CNT_W-1:0]       osc_cycles;
	logic [`CKSS_CNT_W-1:0]       tout_cycles;
	logic [`CKSS_CNT_W-1:0]       reset_cycles;
	logic                         next_reserved;
	logic [`CKSS_CNT_W-1:0]       wdt_count;
	logic [`CKSS_CNT_W-1:0]       osc_count;
	logic                         wdt_clear;
	logic                         osc_clear;
	logic                         tout_done;
	logic                         count_done;
	logic                         in_reset_phase;
	logic                         next_cpu_en;
	logic [7:0]                   next_rdata;

	// latch fuses during reset
	// Plain clocked capture, an async reset may only load constants
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fuse_cksel <= `CKSS_DEF_CKSEL;
			fuse_sut   <= `CKSS_DEF_SUT;
			fuse_div8  <= `CKSS_DEF_DIV8;
		end else if (device_reset_in) begin
			fuse_cksel <= clock_source_select;
			fuse_sut   <= startup_time_select;
			fuse_div8  <= divide_by_eight_fuse;
		end
	end

	always_comb begin
		next_source = ckss_pkg::CKSS_SRC_RC_CAL;
		if (fuse_cksel[3]) begin
			next_source = ckss_pkg::CKSS_SRC_LOWPOWER;
		end else begin
			case (fuse_cksel[3:1])
				`CKSS_RANGE_FULLSWING: next_source = ckss_pkg::CKSS_SRC_FULLSWING;
				`CKSS_RANGE_LOWFREQ:   next_source = ckss_pkg::CKSS_SRC_LOWFREQ;
				default: begin
					case (fuse_cksel)
						`CKSS_CKSEL_RC128K:   next_source = ckss_pkg::CKSS_SRC_RC_128K;
						`CKSS_CKSEL_RCCAL:    next_source = ckss_pkg::CKSS_SRC_RC_CAL;
						`CKSS_CKSEL_RESERVED: next_source = ckss_pkg::CKSS_SRC_RESERVED;
						default:              next_source = ckss_pkg::CKSS_SRC_EXT;
					endcase
				end
			endcase
		end
	end

	// Start-up count and time-out per source
	always_comb begin
		osc_cycles    = `CKSS_OSC_EXT_CYC;
		tout_sel      = ckss_pkg::CKSS_TOUT_LONG;
		next_reserved = 1'h0;
		case (next_source)
			ckss_pkg::CKSS_SRC_LOWPOWER,
			ckss_pkg::CKSS_SRC_FULLSWING: begin
				case ({fuse_cksel[0], fuse_sut})
					3'h0: begin
						osc_cycles = `CKSS_OSC_258_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_SHORT;
					end
					3'h1: begin
						osc_cycles = `CKSS_OSC_258_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_LONG;
					end
					3'h2: begin
						osc_cycles = `CKSS_OSC_1K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_NONE;
					end
					3'h3: begin
						osc_cycles = `CKSS_OSC_1K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_SHORT;
					end
					3'h4: begin
						osc_cycles = `CKSS_OSC_1K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_LONG;
					end
					3'h5: begin
						osc_cycles = C16K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_NONE;
					end
					3'h6: begin
						osc_cycles = C16K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_SHORT;
					end
					default: begin
						osc_cycles = C16K_CYC;
						tout_sel   = ckss_pkg::CKSS_TOUT_LONG;
					end
				endcase
			end
			ckss_pkg::CKSS_SRC_LOWFREQ: begin
				// longest count for a watch crystal
				osc_cycles = fuse_cksel[0] ? C32K_CYC : `CKSS_OSC_1K_CYC;
				case (fuse_sut)
					2'h0:    tout_sel = ckss_pkg::CKSS_TOUT_NONE;
					2'h1:    tout_sel = ckss_pkg::CKSS_TOUT_SHORT;
					2'h2:    tout_sel = ckss_pkg::CKSS_TOUT_LONG;
					default: begin
						// Reserved: safest, longest wait
						tout_sel      = ckss_pkg::CKSS_TOUT_LONG;
						osc_cycles    = C32K_CYC;
						next_reserved = 1'h1;
					end
				endcase
			end
			default: begin
				osc_cycles    = `CKSS_OSC_EXT_CYC;
				next_reserved = (next_source == ckss_pkg::CKSS_SRC_RESERVED);
				case (fuse_sut)
					2'h0:    tout_sel = ckss_pkg::CKSS_TOUT_NONE;
					2'h1:    tout_sel = ckss_pkg::CKSS_TOUT_SHORT;
					default: tout_sel = ckss_pkg::CKSS_TOUT_LONG;
				endcase
			end
		endcase
	end

	always_comb begin
		case (tout_sel)
			ckss_pkg::CKSS_TOUT_NONE:  tout_cycles = `CKSS_TOUT_NONE_CYC;
			ckss_pkg::CKSS_TOUT_SHORT: tout_cycles = `CKSS_TOUT_SHORT_CYC;
			default:                   tout_cycles = LONG_CYC;
		endcase
	end

	assign reset_cycles = osc_cycles + `CKSS_RESET_EXTRA_CYC;

	// delay counted on the watchdog oscillator
	ckss_edge_counter u_wdt_counter (
		.clock   (clock),
		.rst     (rst),
		.osc_pin (wdt_osc_pin),
		.clear   (wdt_clear),
		.count   (wdt_count)
	);

	// synchronous count of the selected oscillator
	ckss_edge_counter u_osc_counter (
		.clock   (clock),
		.rst     (rst),
		.osc_pin (sel_osc_pin),
		.clear   (osc_clear),
		.count   (osc_count)
	);

	assign wdt_clear = (state != ckss_pkg::CKSS_ST_TIMEOUT);
	assign osc_clear = (state != ckss_pkg::CKSS_ST_STARTUP) && (state != ckss_pkg::CKSS_ST_WAKE);
	assign tout_done = (wdt_count >= tout_cycles);

	// reset path counts extra cycles, wake path does not
	assign count_done = (state == ckss_pkg::CKSS_ST_WAKE) ? (osc_count >= osc_cycles)
	                                                      : (osc_count >= reset_cycles);

	// Any reset source overrides every state
	always_comb begin
		next_state = state;
		if (device_reset_in) begin
			next_state = ckss_pkg::CKSS_ST_HOLD;
		end else begin
			case (state)
				ckss_pkg::CKSS_ST_HOLD: begin
					// zero delay trusts the brown-out detector
					if (tout_sel == ckss_pkg::CKSS_TOUT_NONE) begin
						next_state = ckss_pkg::CKSS_ST_STARTUP;
					end else begin
						next_state = ckss_pkg::CKSS_ST_TIMEOUT;
					end
				end
				ckss_pkg::CKSS_ST_TIMEOUT: begin
					if (tout_done) begin
						next_state = ckss_pkg::CKSS_ST_STARTUP;
					end
				end
				ckss_pkg::CKSS_ST_STARTUP: begin
					if (count_done) begin
						next_state = ckss_pkg::CKSS_ST_RUN;
					end
				end
				ckss_pkg::CKSS_ST_RUN: begin
					if (sleep_enter) begin
						next_state = ckss_pkg::CKSS_ST_SLEEP;
					end
				end
				ckss_pkg::CKSS_ST_SLEEP: begin
					if (wake_event) begin
						next_state = ckss_pkg::CKSS_ST_WAKE;
					end
				end
				ckss_pkg::CKSS_ST_WAKE: begin
					if (count_done) begin
						next_state = ckss_pkg::CKSS_ST_RUN;
					end
				end
				default: next_state = ckss_pkg::CKSS_ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ckss_pkg::CKSS_ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// Software clock controls, read back at their address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			control <= `CKSS_CTRL_RESET;
		end else if (reg_write && reg_addr == `CKSS_ADDR_CONTROL) begin
			control <= reg_wdata[2:0];
		end
	end

	assign in_reset_phase = (next_state == ckss_pkg::CKSS_ST_HOLD) ||
	                        (next_state == ckss_pkg::CKSS_ST_TIMEOUT) ||
	                        (next_state == ckss_pkg::CKSS_ST_STARTUP);
	assign next_cpu_en    = (next_state == ckss_pkg::CKSS_ST_RUN) && !control[`CKSS_CTRL_CPU_HALT];

	// Outputs from flops fed from next_state, except async_timer_clock_enable from control, so they change in the same cycle as the state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			internal_reset               <= 1'h1;
			cpu_clock_enable             <= 1'h0;
			flash_interface_clock_enable <= 1'h0;
			async_timer_clock_enable     <= 1'h0;
			converter_clock_enable       <= 1'h0;
		end else begin
			internal_reset               <= in_reset_phase;
			cpu_clock_enable             <= next_cpu_en;
			flash_interface_clock_enable <= next_cpu_en;
			async_timer_clock_enable     <= control[`CKSS_CTRL_ASY_RUN];
			// runs while the CPU is halted
			converter_clock_enable       <= control[`CKSS_CTRL_CONV_RUN] && !in_reset_phase;
		end
	end

	// Source decode registered for the clock generator
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clock_source            <= ckss_pkg::CKSS_SRC_RC_CAL;
			oscillator_range_select <= 3'h0;
			config_reserved         <= 1'h0;
			divide_by_eight         <= 1'h1;
		end else begin
			clock_source            <= next_source;
			// range mode for the low-power crystal
			oscillator_range_select <= fuse_cksel[3] ? fuse_cksel[3:1] : 3'h0;
			config_reserved         <= next_reserved;
			divide_by_eight         <= !fuse_div8;
		end
	end

	// Unmapped or idle reads return zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				`CKSS_ADDR_STATUS:  next_rdata = {config_reserved, clock_source, internal_reset, state};
				`CKSS_ADDR_FUSES:   next_rdata = {1'h0, fuse_div8, fuse_sut, fuse_cksel};
				`CKSS_ADDR_CONTROL: next_rdata = {5'h00, control};
				default:            next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : ckss_sequencer

// file: design/ckss_consts.svh
`ifndef CKSS_CONSTS_SVH
`define CKSS_CONSTS_SVH

// Fuse codes, a fuse bit reads 1 when unprogrammed
`define CKSS_CKSEL_RC128K    4'h3
`define CKSS_CKSEL_RCCAL     4'h2
`define CKSS_CKSEL_RESERVED  4'h1
`define CKSS_CKSEL_EXT       4'h0
`define CKSS_RANGE_FULLSWING 3'h3
`define CKSS_RANGE_LOWFREQ   3'h2
`define CKSS_RANGE_RC        3'h1
`define CKSS_RANGE_EXT       3'h0

// Factory defaults
`define CKSS_DEF_CKSEL       4'h2
`define CKSS_DEF_SUT         2'h2
`define CKSS_DEF_DIV8        1'h0

// Watchdog oscillator cycles of the time-out delay
`define CKSS_TOUT_NONE_CYC   17'h00000
`define CKSS_TOUT_SHORT_CYC  17'h00200
`define CKSS_TOUT_LONG_CYC   17'h02000

// Selected oscillator cycles of the start-up count
`define CKSS_OSC_EXT_CYC     17'h00006
`define CKSS_OSC_258_CYC     17'h00102
`define CKSS_OSC_1K_CYC      17'h00400
`define CKSS_OSC_16K_CYC     17'h04000
`define CKSS_OSC_32K_CYC     17'h08000
`define CKSS_RESET_EXTRA_CYC 17'h0000E

// Register port
`define CKSS_CNT_W           17
`define CKSS_ADDR_STATUS     2'h0
`define CKSS_ADDR_FUSES      2'h1
`define CKSS_ADDR_CONTROL    2'h2
`define CKSS_CTRL_CPU_HALT   0
`define CKSS_CTRL_CONV_RUN   1
`define CKSS_CTRL_ASY_RUN    2
`define CKSS_CTRL_RESET      3'h4

`endif

// file: design/ckss_pkg.sv
package ckss_pkg;

	typedef enum logic [2:0] {
		CKSS_SRC_EXT       = 3'h0,
		CKSS_SRC_RESERVED  = 3'h1,
		CKSS_SRC_RC_CAL    = 3'h2,
		CKSS_SRC_RC_128K   = 3'h3,
		CKSS_SRC_LOWFREQ   = 3'h4,
		CKSS_SRC_FULLSWING = 3'h5,
		CKSS_SRC_LOWPOWER  = 3'h6
	} ckss_source_e;

	typedef enum logic [2:0] {
		CKSS_ST_HOLD    = 3'h0,
		CKSS_ST_TIMEOUT = 3'h1,
		CKSS_ST_STARTUP = 3'h3,
		CKSS_ST_RUN     = 3'h2,
		CKSS_ST_SLEEP   = 3'h6,
		CKSS_ST_WAKE    = 3'h7
	} ckss_state_e;

	typedef enum logic [1:0] {
		CKSS_TOUT_NONE  = 2'h0,
		CKSS_TOUT_SHORT = 2'h1,
		CKSS_TOUT_LONG  = 2'h2
	} ckss_tout_e;

endpackage : ckss_pkg

// file: design/ckss_edge_counter.sv
`timescale 1ns/100ps
`include "ckss_consts.svh"

module ckss_edge_counter (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    osc_pin,
	input  wire logic                    clear,
	output logic      [`CKSS_CNT_W-1:0]  count
);

	logic sync1;
	logic sync2;
	logic sync3;
	logic level;

	// Pin from a foreign oscillator, three stages
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1 <= 1'h0;
			sync2 <= 1'h0;
			sync3 <= 1'h0;
		end else begin
			sync1 <= osc_pin;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			level <= 1'h0;
		end else if (sync2 == sync3) begin
			level <= sync3;
		end
	end

	// Synchronous count of rising edges, saturates
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (sync2 == sync3 && sync3 && !level && count != '1) begin
			count <= count + `CKSS_CNT_W'(1);
		end
	end

endmodule : ckss_edge_counter

// file: tb/ckss_far_model.sv
`timescale 1ns/100ps
module ckss_far_model #(
	parameter int WDT_HALF = 2,
	parameter int SEL_HALF = 3
) (
	input  wire logic clock,
	output logic      wdt_osc_pin,
	output logic      sel_osc_pin,
	output logic      device_reset_in,
	output logic      sleep_enter,
	output logic      wake_event
);
	int wdt_n;
	int sel_n;

	initial begin
		wdt_osc_pin = 1'b0;
		sel_osc_pin = 1'b0;
		device_reset_in = 1'b1;
		sleep_enter = 1'b0;
		wake_event = 1'b0;
		wdt_n = 0;
		sel_n = 0;
	end

	// Two rates, so counting the wrong oscillator shows in the timing
	always @(posedge clock) begin
		wdt_n <= (wdt_n == WDT_HALF - 1) ? 0 : wdt_n + 1;
		sel_n <= (sel_n == SEL_HALF - 1) ? 0 : sel_n + 1;
		if (wdt_n == WDT_HALF - 1)
			wdt_osc_pin <= !wdt_osc_pin;
		if (sel_n == SEL_HALF - 1)
			sel_osc_pin <= !sel_osc_pin;
	end

	task automatic release_reset();
		@(posedge clock);
		device_reset_in <= 1'b1;
		@(posedge clock);
		@(posedge clock);
		device_reset_in <= 1'b0;
	endtask : release_reset

	task automatic pulse_sleep();
		@(posedge clock);
		sleep_enter <= 1'b1;
		@(posedge clock);
		sleep_enter <= 1'b0;
	endtask : pulse_sleep

	task automatic pulse_wake();
		@(posedge clock);
		wake_event <= 1'b1;
		@(posedge clock);
		wake_event <= 1'b0;
	endtask : pulse_wake
endmodule : ckss_far_model

// file: tb/ckss_monitor.sv
`timescale 1ns/100ps
module ckss_monitor (
	input wire logic                   clock,
	input wire logic                   rst,
	input wire logic                   device_reset_in,
	input wire logic                   sleep_enter,
	input wire logic [1:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_write,
	input wire logic                   internal_reset,
	input wire logic                   cpu_clock_enable,
	input wire logic                   flash_interface_clock_enable,
	input wire logic                   async_timer_clock_enable,
	input wire logic                   converter_clock_enable,
	input wire logic                   divide_by_eight,
	input wire ckss_pkg::ckss_source_e clock_source,
	input wire logic [2:0]             oscillator_range_select,
	input wire logic                   config_reserved
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_flash; flash_interface_clock_enable == cpu_clock_enable; endproperty
	a_flash: assert property (p_flash) else $error("flash enable differs from cpu enable");
	property p_hold_cpu; internal_reset |-> !cpu_clock_enable; endproperty
	a_hold_cpu: assert property (p_hold_cpu) else $error("cpu clock runs during reset");
	property p_async; reg_write && reg_addr == 2'h2 |-> ##2 async_timer_clock_enable == $past(reg_wdata[2], 2);
	endproperty
	a_async: assert property (p_async) else $error("async timer enable not from control");
	property p_conv; internal_reset && $past(internal_reset) |-> !converter_clock_enable; endproperty
	a_conv: assert property (p_conv) else $error("converter clock on in reset");
	property p_fuse_hold;
		!internal_reset && !$past(device_reset_in) && !$past(device_reset_in, 2) && !$past(device_reset_in, 3)
		|-> $stable(clock_source) && $stable(divide_by_eight) && $stable(oscillator_range_select);
	endproperty
	a_fuse_hold: assert property (p_fuse_hold) else $error("latched fuse outputs changed");
	property p_range; (clock_source == ckss_pkg::CKSS_SRC_LOWPOWER) == oscillator_range_select[2]; endproperty
	a_range: assert property (p_range) else $error("range select disagrees with source");
	property p_resv;
		config_reserved |-> clock_source == ckss_pkg::CKSS_SRC_RESERVED || clock_source == ckss_pkg::CKSS_SRC_LOWFREQ;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved flag with wrong source");
	property p_release; $fell(internal_reset) |-> !$past(device_reset_in) && !$past(device_reset_in, 8); endproperty
	a_release: assert property (p_release) else $error("reset released too early");
	property p_sleep; sleep_enter && cpu_clock_enable |-> ##2 !cpu_clock_enable; endproperty
	a_sleep: assert property (p_sleep) else $error("cpu clock kept in sleep");

	c_run: cover property ($fell(internal_reset));
	c_sleep: cover property (sleep_enter && cpu_clock_enable);
	c_resv: cover property (config_reserved);
endmodule : ckss_monitor

bind ckss_sequencer ckss_monitor i_mon (.clock, .rst, .device_reset_in, .sleep_enter, .reg_addr, .reg_wdata,
	.reg_write, .internal_reset, .cpu_clock_enable, .flash_interface_clock_enable, .async_timer_clock_enable,
	.converter_clock_enable, .divide_by_eight, .clock_source, .oscillator_range_select, .config_reserved);

// file: tb/tb_clock_source_startup_sequencer.sv
`timescale 1ns/100ps
module tb_clock_source_startup_sequencer;
	logic                   clock;
	logic                   rst;
	logic                   div_fuse;
	logic                   reg_write;
	logic                   reg_read;
	logic [3:0]             cksel;
	logic [1:0]             sut;
	logic [1:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic [7:0]             reg_rdata;
	logic                   wdt_pin, sel_pin, dev_rst, sleep_en, wake_ev;
	logic                   int_rst, cpu_en, fl_en, asy_en, conv_en, div8, resv;
	logic [2:0]             range;
	ckss_pkg::ckss_source_e src;
	int                     fails;
	int                     n_compared;
	int                     cycles;
	int                     c;

	initial begin
		clock = 1'b0;
		forever #25 clock = !clock;
	end

	ckss_far_model #(.WDT_HALF(2), .SEL_HALF(3)) i_far (.clock(clock), .wdt_osc_pin(wdt_pin),
		.sel_osc_pin(sel_pin), .device_reset_in(dev_rst), .sleep_enter(sleep_en), .wake_event(wake_ev));

	// Shortened long counts keep the run brief
	ckss_sequencer #(.TOUT_LONG_CYC(40), .OSC_16K_CYC(30), .OSC_32K_CYC(50)) i_dut (.clock(clock), .rst(rst),
		.device_reset_in(dev_rst), .clock_source_select(cksel), .startup_time_select(sut),
		.divide_by_eight_fuse(div_fuse), .wdt_osc_pin(wdt_pin), .sel_osc_pin(sel_pin), .sleep_enter(sleep_en),
		.wake_event(wake_ev), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .internal_reset(int_rst), .cpu_clock_enable(cpu_en),
		.flash_interface_clock_enable(fl_en), .async_timer_clock_enable(asy_en),
		.converter_clock_enable(conv_en), .divide_by_eight(div8), .clock_source(src),
		.oscillator_range_select(range), .config_reserved(resv));

	task automatic report_and_stop();
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	always @(posedge clock) begin
		cycles <= cycles + 1;
	end

	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8

	// Edge sync slack allows up to 16 cycles early and up to 30 cycles late
	task automatic cmp_rng(input string what, input int exp, input int got);
		n_compared++;
		if (got < exp - 16 || got > exp + 30) begin
			fails++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : cmp_rng

	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 cmp8(what, exp, reg_rdata);
	endtask : reg_chk

	function automatic logic [7:0] enables();
		return {3'h0, cpu_en, fl_en, asy_en, conv_en, int_rst};
	endfunction : enables

	// Fuses flipped once the sequence runs; outputs must not follow
	task automatic run_seq(input logic [3:0] cs, input logic [1:0] st, input logic dv, input int tout, input int osc,
		input logic [7:0] exp);
		@(posedge clock);
		cksel <= cs;
		sut <= st;
		div_fuse <= dv;
		i_far.release_reset();
		cksel <= ~cs;
		sut <= ~st;
		div_fuse <= ~dv;
		c = 0;
		#1;
		while (int_rst !== 1'b0 && c < 20000) begin
			@(posedge clock);
			#1 c++;
		end
		cmp_rng("start-up cycles", tout * 4 + osc * 6, c);
		cmp8("source fields", exp, {div8, resv, range, src});
	endtask : run_seq

	initial begin
		rst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		cksel = 4'h2;
		sut = 2'h2;
		div_fuse = 1'b0;
		fails = 0;
		n_compared = 0;
		// Watchdog for the whole run, a hang counts as a mismatch
		fork
			begin
				wait (cycles == 60000);
				fails++;
				report_and_stop();
			end
		join_none
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		#1 cmp8("default fields", 8'h82, {div8, resv, range, src});
		reg_chk("status", 2'h0, 8'h28);
		reg_chk("fuses", 2'h1, 8'h22);
		reg_chk("control", 2'h2, 8'h04);
		reg_chk("unmapped", 2'h3, 8'h00);
		run_seq(4'hE, 2'h0, 1'b1, 512, 272, 8'h3E);
		run_seq(4'h8, 2'h2, 1'b0, 0, 1038, 8'hA6);
		run_seq(4'h6, 2'h2, 1'b1, 0, 1038, 8'h05);
		run_seq(4'h5, 2'h1, 1'b1, 512, 64, 8'h04);
		run_seq(4'h4, 2'h3, 1'b1, 40, 64, 8'h44);
		run_seq(4'h3, 2'h3, 1'b1, 40, 20, 8'h03);
		run_seq(4'h0, 2'h0, 1'b1, 0, 20, 8'h00);
		run_seq(4'h1, 2'h0, 1'b1, 0, 20, 8'h41);
		run_seq(4'h9, 2'h0, 1'b1, 40, 1038, 8'h26);
		run_seq(4'h2, 2'h2, 1'b0, 40, 20, 8'h82);
		run_seq(4'hF, 2'h1, 1'b0, 0, 44, 8'hBE);
		reg_wr(2'h3, 8'hFF);
		reg_wr(2'h0, 8'hFF);
		reg_wr(2'h1, 8'h00);
		reg_chk("fuses held", 2'h1, 8'h1F);
		reg_chk("status run", 2'h0, 8'h62);
		reg_chk("unmapped", 2'h3, 8'h00);
		reg_wr(2'h2, 8'h06);
		repeat (2) @(posedge clock);
		#1 cmp8("run enables", 8'h1E, enables());
		i_far.pulse_sleep();
		repeat (3) @(posedge clock);
		#1 cmp8("sleep enables", 8'h06, enables());
		reg_chk("status sleep", 2'h0, 8'h66);
		i_far.pulse_wake();
		c = 0;
		#1;
		while (cpu_en !== 1'b1 && c < 2000) begin
			@(posedge clock);
			#1 c++;
		end
		cmp_rng("wake cycles", 180, c);
		cmp8("wake enables", 8'h1E, enables());
		reg_wr(2'h2, 8'h01);
		repeat (2) @(posedge clock);
		#1 cmp8("halt enables", 8'h00, enables());
		reg_chk("control", 2'h2, 8'h01);
		report_and_stop();
	end
endmodule : tb_clock_source_startup_sequencer
